// ==== shared/cfg_link_if.sv ====
/*
 * the three-wire link between host and device.
 * assumes the bench resolves the shared data line from the two enables.
 */
`timescale 1ns/1ps
interface cfg_link_if;
   logic serial_select_n; // host drives, active low
   logic sck;             // host drives
   logic sdio_host_out;
   logic sdio_host_oe;
   logic sdio_dev_out;
   logic sdio_dev_oe;
   logic sdio_in;         // resolved line level, driven by bench
   modport device (input serial_select_n, input sck, input sdio_in,
                   output sdio_dev_out, output sdio_dev_oe);
   modport host (output serial_select_n, output sck, input sdio_in,
                 output sdio_host_out, output sdio_host_oe);
endinterface

// ==== shared/cfg_port_pkg.sv ====
/*
 * constants shared by both ends of the three-wire configuration port:
 * frame layout, command codes, register indices and field positions.
 * assumes the host and device run on the same 200 MHz system clock domain family.
 */
package cfg_port_pkg;
   // ==========================================================
   // frame layout
   localparam int ADDR_BITS = 8;
   localparam int DATA_BITS = 16;
   localparam int FRAME_BITS = 24;
   localparam int ID_BYTES = 4;
   localparam logic [4:0] CNT_A4 = 5'h03; // address bit 4 is the fourth bit
   localparam logic [5:0] CNT_ID_LAST = 6'h20; // count at which the last id byte begins
   localparam logic [5:0] ID_FRAME_BITS = 6'h28;
   // ==========================================================
   // command field, address bits 6..4
   localparam logic [1:0] CMD_CTRL = 2'h0;
   localparam logic [1:0] CMD_ID = 2'h1;
   localparam logic [1:0] CMD_FIFO = 2'h2;
   localparam logic [2:0] CMD_PTR_RESET = 3'h6;
   localparam logic [2:0] CMD_CHIP_RESET = 3'h7;
   // ==========================================================
   // register map
   localparam logic [3:0] REG_PIN_CONTROL = 4'hd;
   localparam logic [3:0] REG_CALIBRATION = 4'he;
   localparam logic [3:0] REG_MODE_CONTROL = 4'hf;
   localparam logic [15:0] MODE_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] PIN_CONTROL_RESET = 16'h0005;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [31:0] ID_RESET = 32'h0000_0000; // arbitrary neutral value
   // mode control and pin control bits
   localparam int MC_MEASURE = 0;
   localparam int MC_FB_CAL = 1;
   localparam int MC_OSC_CAL = 2;
   localparam int MC_TRX_EN = 3;
   localparam int MC_DIR = 4;
   localparam int MC_SYNTH = 5;
   localparam int MC_CHIP_ON = 6;
   localparam int MC_PKT_MODE = 7;
   localparam int MC_PKT_TEST = 8;
   localparam int MC_CRC_ERR = 9;
   localparam int MC_FEC_ERR = 10;
   localparam int PC_CLK_INV = 0;
   // tuning voltage status codes
   localparam logic [1:0] TV_LOW = 2'h0;
   localparam logic [1:0] TV_MID = 2'h1;
   localparam logic [1:0] TV_HIGH = 2'h3;
   // host serial clock divider: half period in system clocks (10 MHz max)
   localparam int SCK_HALF_NS = 50;
   localparam int CLOCK_NS = 5;
   localparam logic [3:0] SCK_HALF_CYCLES = 4'((SCK_HALF_NS + CLOCK_NS - 1) / CLOCK_NS);
endpackage

// ==== verification/cfg_link_sva.sv ====
/*
 * checker for the three-wire link that joins the host and device ends.
 * assumes one system clock for both ends and the bench's synchronous active-high reset.
 */
`timescale 1ns/1ps
module cfg_link_sva (
   input wire logic clock, // system clock
   input wire logic rst, // sync reset, active high
   input wire logic serial_select_n, // frame select, low active
   input wire logic sck, // link clock from the host
   input wire logic sdio_host_out, // host data
   input wire logic sdio_host_oe, // host drives the line
   input wire logic sdio_dev_out, // device data
   input wire logic sdio_dev_oe, // device drives the line
   input wire logic sdio_in // resolved line level
);
   // ==========================================================
   // shared sequences
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence high_phase;
      sck [*8];
   endsequence
   sequence idle_gap;
      serial_select_n [*4];
   endsequence
   // ==========================================================
   // link assertions
   chk_no_contention: assert property (!(sdio_host_oe && sdio_dev_oe))
      else $error("both ends drive the data line");
   chk_high_phase: assert property ($rose(sck) |-> high_phase)
      else $error("link clock high phase too short");
   chk_sck_in_frame: assert property ($rose(sck) |-> !serial_select_n)
      else $error("link clock pulse outside a frame");
   chk_idle_low: assert property (serial_select_n && $past(serial_select_n) |-> !sck)
      else $error("link clock not idle low between frames");
   chk_host_setup: assert property (sdio_host_oe && $changed(sdio_host_out) |-> !sck)
      else $error("host data moved while link clock high");
   chk_dev_update: assert property (
      sdio_dev_oe && $past(sdio_dev_oe) && $changed(sdio_dev_out) |-> !sck && !$past(sck))
      else $error("device data moved away from a falling edge");
   chk_dev_quiet: assert property (idle_gap |-> !sdio_dev_oe)
      else $error("device drives the line while deselected");
   chk_frame_start: assert property ($fell(serial_select_n) |-> ##[8:12] $rose(sck))
      else $error("first link clock edge late after select");
endmodule

// ==== verification/tb.sv ====
/*
 * self-checking bench: host end and device end joined by the link interface.
 * assumes a zero-wait apb host and a data line that pulls up when nobody drives it.
 */
`timescale 1ns/1ps
module tb;
   // ==========================================================
   // signals
   logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, slverr;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic rx_state = 0, measure_done = 0, measure_single = 0, filter_cal_done = 0;
   logic osc_cal_done = 0, end_of_packet = 0, filter_bank_fail = 0, osc_bank_fail = 0;
   logic tune_above_low = 0, tune_above_high = 0, checksum_error_flag = 0;
   logic correction_error_flag = 0;
   logic [3:0] filter_bank_result = 0;
   logic [2:0] osc_bank_result = 0;
   logic [4:0] filter_cal_deviation = 0;
   logic [7:0] fifo_rdata = 0, fifo_wdata;
   logic measure_start, measure_rssi, filter_bank_cal_start, osc_bank_cal_start, tx_active;
   logic rx_active, synth_enable, chip_on, packet_mode_select, packet_test_mode;
   logic fifo_write, fifo_read, tx_ptr_reset, rx_ptr_reset;
   logic [8:0] mode;
   logic [15:0] d;
   logic [7:0] wq[$];
   int err_count = 0, checked = 0, n_rd = 0, n_tx = 0, n_rx = 0;
   cfg_link_if link();
   // free line floats to its pull-up
   assign link.sdio_in = link.sdio_dev_oe ? link.sdio_dev_out :
      link.sdio_host_oe ? link.sdio_host_out : 1'b1;
   initial forever #2.5 clock = ~clock;
   cfg_port_host u_cfg_port_host (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .link(link.host));
   cfg_port_device u_cfg_port_device (.clock, .rst, .link(link.device), .rx_state,
      .measure_done, .measure_single, .filter_cal_done, .osc_cal_done, .end_of_packet,
      .filter_bank_result, .filter_bank_fail, .osc_bank_result, .osc_bank_fail,
      .tune_above_low, .tune_above_high, .filter_cal_deviation, .checksum_error_flag,
      .correction_error_flag, .measure_start, .measure_rssi, .filter_bank_cal_start,
      .osc_bank_cal_start, .tx_active, .rx_active, .synth_enable, .chip_on,
      .packet_mode_select, .packet_test_mode, .fifo_write, .fifo_read, .fifo_wdata,
      .fifo_rdata, .tx_ptr_reset, .rx_ptr_reset);
   cfg_link_sva u_cfg_link_sva (.clock, .rst, .serial_select_n(link.serial_select_n),
      .sck(link.sck), .sdio_host_out(link.sdio_host_out), .sdio_host_oe(link.sdio_host_oe),
      .sdio_dev_out(link.sdio_dev_out), .sdio_dev_oe(link.sdio_dev_oe),
      .sdio_in(link.sdio_in));
   // ==========================================================
   // pulse monitor: one count per strobe cycle
   always @(posedge clock) begin
      if (fifo_write === 1'b1) wq.push_back(fifo_wdata);
      n_rd += int'(fifo_read === 1'b1);
      n_tx += int'(tx_ptr_reset === 1'b1);
      n_rx += int'(rx_ptr_reset === 1'b1);
   end
   // ==========================================================
   // tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task summarize;
      if (err_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one apb transfer, held until pready is seen high
   task apb(input logic wr, input logic [31:0] a, input logic [31:0] dat);
      @(posedge clock);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dat;
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      slverr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // play one frame and wait for the host to go idle
   task frame(input logic [7:0] a, input logic [15:0] dat);
      int i;
      apb(1, 32'h0, {8'h00, a, dat});
      i = 0;
      do begin
         apb(0, 32'h8, 0);
         i++;
      end while (rd[0] !== 1'b0 && i < 400);
      if (i >= 400) err_count++;
      repeat (6) @(posedge clock); // device needs a few clocks of select high
   endtask
   task rdreg(input logic [7:0] a);
      frame(a, 16'h0000);
      apb(0, 32'hc, 0);
   endtask
   task chk_mode(input logic [8:0] m);
      chk({measure_start, filter_bank_cal_start, osc_bank_cal_start, tx_active, rx_active,
         synth_enable, chip_on, packet_mode_select, packet_test_mode}, {m[0], m[1], m[2],
         m[3] & m[4], m[3] & !m[4], m[5], m[6], m[7], m[8] & m[7]});
   endtask
   task rnd_status;
      int lvl;
      lvl = $urandom % 3;
      {rx_state, filter_bank_fail, osc_bank_fail, checksum_error_flag, correction_error_flag,
         filter_bank_result, osc_bank_result, filter_cal_deviation} <= 17'($urandom);
      tune_above_low <= lvl > 0;
      tune_above_high <= lvl == 2;
   endtask
   // ==========================================================
   // watchdog, well past the expected run of about 12k clocks
   initial begin
      #400000;
      err_count++;
      summarize;
   end
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(85310));
      repeat (16) @(posedge clock);
      rst <= 0;
      apb(0, 32'h10, 0);
      chk(slverr, 1'b1); // unmapped host address refused
      // clock invert is on after reset, so the device lags one bit: send 25
      apb(1, 32'h4, 32'd17);
      frame(8'h06, 16'h8000);
      apb(1, 32'h4, 32'd16);
      repeat (4) begin
         mode = 9'($urandom);
         mode[8] = mode[8] & mode[7]; // test bit only together with packet mode
         rnd_status;
         frame(8'h0f, {7'h00, mode});
         chk_mode(mode);
         chk(measure_rssi, rx_state);
         rdreg(8'h8f);
         chk(rd[15:0], {5'h00, correction_error_flag, checksum_error_flag, mode});
         rdreg(8'h8e);
         chk(rd[15:0], {filter_cal_deviation, tune_above_high, tune_above_low, osc_bank_fail,
            osc_bank_result, filter_bank_fail, filter_bank_result});
      end
      // self clearing bits on their completion events
      measure_single <= 1;
      frame(8'h0f, 16'h01cf);
      chk_mode(9'h1cf);
      @(posedge clock);
      {measure_done, filter_cal_done, osc_cal_done, end_of_packet} <= 4'hf;
      @(posedge clock);
      {measure_done, filter_cal_done, osc_cal_done, end_of_packet} <= 4'h0;
      repeat (3) @(posedge clock);
      chk_mode(9'h0c0);
      // fifo load and unload, two bytes a word
      d = 16'($urandom);
      frame(8'h40, d);
      chk(wq.size(), 2);
      chk({wq[0], wq[1]}, d);
      fifo_rdata <= 8'($urandom);
      rdreg(8'hc0);
      chk(rd[15:0], {fifo_rdata, fifo_rdata});
      chk(n_rd, 2);
      // id code: four bytes in, read back whole, then cut short after two
      d = 16'($urandom);
      apb(1, 32'h4, 32'd32);
      frame(8'h20, d);
      rdreg(8'ha0);
      chk(rd, {d, 16'h0000});
      apb(1, 32'h4, 32'd16);
      rdreg(8'ha0);
      chk(rd[15:0], d);
      // pointer resets pick the fifo by the direction bit
      frame(8'h60, 16'hffff);
      chk(n_tx, 1);
      chk(n_rx, 0);
      frame(8'he0, 16'h0000);
      chk(n_rx, 1);
      // chip reset with the direction bit set still resets
      frame(8'hf0, 16'h0000);
      chk_mode(9'h000);
      summarize;
   end
endmodule

// ==== verilog/cfg_port_device.sv ====
/*
 * device end of the three-wire configuration port with mode control and
 * calibration status. samples the link pins on its own clock.
 * assumes the host follows the frame format and keeps each sck phase >= 3 clocks.
 */
// What this block does
// - frame is 8 address then 16 data, msb first
// - sample data on rising sck edge
// - load register only after sixteenth data bit
// - registers kept through power down mode
// - read data driven, updated on falling edges
// - address bits 6..4 select the command
// - low four address bits pick register
// - bit seven set reads, clear writes
// - pointer reset zeroes tx or rx pointer
// - chip reset command restores all registers
// - id access moves four bytes, may stop early
// - measure bit starts adc, self clears in single mode
// - calibration bits start and self clear
// - report banks with pass fail flags
// - tuning status codes 00 01 11
// - five bit filter deviation reported
// - enable picks tx or rx, clears eop in packet mode
// - packet mode, chip and synth enables
// - test bit needs packet mode, clears eop
// - mode read adds crc and fec flags
// - pin control bit inverts serial clock
`timescale 1ns/1ps
module cfg_port_device (
   input wire logic clock, // system clock
   input wire logic rst, // synchronous, active high
   cfg_link_if.device link, // three-wire link
   input wire logic rx_state, // transceiver is receiving
   input wire logic measure_done, // adc measurement finished, pulse
   input wire logic measure_single, // adc in single mode
   input wire logic filter_cal_done, // filter calibration finished, pulse
   input wire logic osc_cal_done, // oscillator calibration finished, pulse
   input wire logic end_of_packet, // packet finished, pulse
   input wire logic [3:0] filter_bank_result, // chosen filter bank
   input wire logic filter_bank_fail, // 1 fail
   input wire logic [2:0] osc_bank_result, // chosen oscillator bank
   input wire logic osc_bank_fail, // 1 fail
   input wire logic tune_above_low, // tuning voltage above low threshold
   input wire logic tune_above_high, // tuning voltage above high threshold
   input wire logic [4:0] filter_cal_deviation, // distance from goal
   input wire logic checksum_error_flag, // crc error
   input wire logic correction_error_flag, // fec error
   output logic measure_start, // adc measurement request
   output logic measure_rssi, // 1 signal strength, 0 temperature
   output logic filter_bank_cal_start, // calibration request
   output logic osc_bank_cal_start, // calibration request
   output logic tx_active, // transmit state
   output logic rx_active, // receive state
   output logic synth_enable, // pll enable
   output logic chip_on, // chip enable
   output logic packet_mode_select, // 1 fifo packet mode
   output logic packet_test_mode, // fifo test mode
   output logic fifo_write, // tx fifo byte strobe, pulse
   output logic fifo_read, // rx fifo byte strobe, pulse
   output logic [7:0] fifo_wdata, // byte for tx fifo
   input wire logic [7:0] fifo_rdata, // byte from rx fifo
   output logic tx_ptr_reset, // pulse
   output logic rx_ptr_reset // pulse
);
   // ==========================================================
   // pin synchronisers; first stage read only by the second
   logic [1:0] sel_sync, sck_sync, sdi_sync;
   logic sck_q;
   always_ff @(posedge clock) begin
      sel_sync <= {sel_sync[0], link.serial_select_n};
      sck_sync <= {sck_sync[0], link.sck};
      sdi_sync <= {sdi_sync[0], link.sdio_in};
      sck_q <= sck_sync[1];
   end
   logic [15:0] regs [16];
   logic [31:0] id_code;
   logic clk_inv;
   assign clk_inv = regs[cfg_port_pkg::REG_PIN_CONTROL][cfg_port_pkg::PC_CLK_INV];
   // edge detection after optional inversion
   logic sck_now, sck_old, sck_rise, sck_fall, sel_n;
   assign sck_now = sck_sync[1] ^ clk_inv;
   assign sck_old = sck_q ^ clk_inv;
   assign sel_n = sel_sync[1];
   assign sck_rise = !sel_n && sck_now && !sck_old;
   assign sck_fall = !sel_n && !sck_now && sck_old;
   // ==========================================================
   // frame decode
   logic [5:0] bit_cnt;
   logic [7:0] addr;
   logic [15:0] shift_in;
   logic [15:0] shift_out;
   logic is_read, busy;
   assign is_read = addr[7];
   always_ff @(posedge clock) begin
      if (rst || sel_n) begin
         bit_cnt <= 6'h00;
      end else if (sck_rise) begin
         bit_cnt <= bit_cnt + 6'h01;
      end
   end
   // msb first shift of address then data
   always_ff @(posedge clock) begin
      if (rst) begin
         addr <= 8'h00;
         shift_in <= 16'h0000;
      end else if (sck_rise) begin
         if (bit_cnt < 6'(cfg_port_pkg::ADDR_BITS)) begin
            addr <= {addr[6:0], sdi_sync[1]};
         end
         shift_in <= {shift_in[14:0], sdi_sync[1]};
      end
   end
   // command decode, valid once the address byte is in
   logic [2:0] cmd;
   logic cmd_ctrl, cmd_id, cmd_fifo, addr_done;
   assign cmd = addr[6:4];
   assign addr_done = bit_cnt >= 6'(cfg_port_pkg::ADDR_BITS);
   assign cmd_ctrl = cmd[2:1] == cfg_port_pkg::CMD_CTRL;
   assign cmd_id = cmd[2:1] == cfg_port_pkg::CMD_ID;
   assign cmd_fifo = cmd[2:1] == cfg_port_pkg::CMD_FIFO;
   // bit four falls: count 4 done, address bits 7..4 known
   logic a4_fall, a4_reset, a4_ptr;
   assign a4_fall = sck_fall && bit_cnt == 6'h04;
   assign a4_reset = a4_fall && addr[2:0] == cfg_port_pkg::CMD_CHIP_RESET;
   assign a4_ptr = a4_fall && addr[2:0] == cfg_port_pkg::CMD_PTR_RESET;
   // end of data word and id byte boundaries
   logic word_done, byte_done;
   assign word_done = sck_rise && bit_cnt == 6'(cfg_port_pkg::FRAME_BITS - 1);
   assign byte_done = sck_rise && addr_done && bit_cnt[2:0] == 3'h7;
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_ptr_reset <= 1'b0;
         rx_ptr_reset <= 1'b0;
      end else begin
         tx_ptr_reset <= a4_ptr && !addr[3];
         rx_ptr_reset <= a4_ptr && addr[3];
      end
   end
   // fifo byte strobes every eighth data bit
   always_ff @(posedge clock) begin
      if (rst) begin
         fifo_write <= 1'b0;
         fifo_read <= 1'b0;
         fifo_wdata <= 8'h00;
      end else begin
         fifo_write <= byte_done && cmd_fifo && !is_read;
         fifo_read <= sck_fall && addr_done && bit_cnt[2:0] == 3'h0 && cmd_fifo && is_read;
         if (byte_done) begin
            fifo_wdata <= {shift_in[6:0], sdi_sync[1]};
         end
      end
   end
   // id code: four bytes, byte zero first; ends itself after the fourth
   always_ff @(posedge clock) begin
      if (rst || a4_reset) begin
         id_code <= cfg_port_pkg::ID_RESET;
      end else if (byte_done && cmd_id && !is_read && bit_cnt < cfg_port_pkg::ID_FRAME_BITS) begin
         id_code <= {id_code[23:0], shift_in[6:0], sdi_sync[1]};
      end
   end
   // ==========================================================
   // control registers; only a power-up reset or chip reset clears them,
   // so a programmed power down keeps them
   logic mc_wr;
   assign mc_wr = word_done && cmd_ctrl && !is_read
      && addr[3:0] == cfg_port_pkg::REG_MODE_CONTROL;
   for (genvar r = 0; r < 16; r++) begin : g_reg
      if (r == cfg_port_pkg::REG_MODE_CONTROL) begin : g_mc
         logic [15:0] next_mc;
         always_comb begin
            next_mc = regs[r];
            if (measure_done && measure_single) next_mc[cfg_port_pkg::MC_MEASURE] = 1'b0;
            if (filter_cal_done) next_mc[cfg_port_pkg::MC_FB_CAL] = 1'b0;
            if (osc_cal_done) next_mc[cfg_port_pkg::MC_OSC_CAL] = 1'b0;
            if (end_of_packet && regs[r][cfg_port_pkg::MC_PKT_MODE]) begin
               next_mc[cfg_port_pkg::MC_TRX_EN] = 1'b0;
               next_mc[cfg_port_pkg::MC_PKT_TEST] = 1'b0;
            end
            // a host write in the same cycle wins: it is the newer request
            if (mc_wr) next_mc = {7'h00, shift_in[7:0], sdi_sync[1]};
         end
         always_ff @(posedge clock) begin
            if (rst || a4_reset) begin
               regs[r] <= cfg_port_pkg::MODE_CONTROL_RESET;
            end else begin
               regs[r] <= next_mc;
            end
         end
      end else begin : g_plain
         always_ff @(posedge clock) begin
            if (rst || a4_reset) begin
               regs[r] <= (r == cfg_port_pkg::REG_PIN_CONTROL) ?
                  cfg_port_pkg::PIN_CONTROL_RESET : cfg_port_pkg::REG_RESET;
            end else if (word_done && cmd_ctrl && !is_read && addr[3:0] == 4'(r)) begin
               regs[r] <= {shift_in[14:0], sdi_sync[1]};
            end
         end
      end
   end
   // ==========================================================
   // read-back values
   logic [1:0] tune_status;
   assign tune_status = tune_above_high ? cfg_port_pkg::TV_HIGH :
      (tune_above_low ? cfg_port_pkg::TV_MID : cfg_port_pkg::TV_LOW);
   logic [15:0] read_word;
   always_comb begin
      read_word = regs[addr[3:0]];
      if (addr[3:0] == cfg_port_pkg::REG_CALIBRATION) begin
         read_word = {filter_cal_deviation, tune_status, osc_bank_fail, osc_bank_result,
            filter_bank_fail, filter_bank_result};
      end else if (addr[3:0] == cfg_port_pkg::REG_MODE_CONTROL) begin
         read_word = {5'h00, correction_error_flag, checksum_error_flag,
            regs[cfg_port_pkg::REG_MODE_CONTROL][8:0]};
      end
   end
   // output shifter: loaded at the fall ending the address, shifted each fall
   always_ff @(posedge clock) begin
      if (rst) begin
         shift_out <= 16'h0000;
         busy <= 1'b0;
      end else if (sel_n) begin
         busy <= 1'b0;
      end else if (sck_fall && bit_cnt == 6'(cfg_port_pkg::ADDR_BITS)) begin
         busy <= is_read;
         shift_out <= cmd_id ? id_code[31:16] : (cmd_fifo ? {fifo_rdata, 8'h00} : read_word);
      end else if (sck_fall && bit_cnt > 6'(cfg_port_pkg::ADDR_BITS)) begin
         shift_out <= {shift_out[14:0], 1'b0};
         if (cmd_id && bit_cnt == 6'h18) shift_out <= id_code[15:0];
         if (cmd_fifo && bit_cnt[2:0] == 3'h0) shift_out <= {fifo_rdata, 8'h00};
         if (cmd_id && bit_cnt >= cfg_port_pkg::ID_FRAME_BITS) busy <= 1'b0;
         if (!cmd_id && !cmd_fifo && bit_cnt >= 6'(cfg_port_pkg::FRAME_BITS)) busy <= 1'b0;
      end
   end
   assign link.sdio_dev_out = shift_out[15];
   assign link.sdio_dev_oe = busy && !sel_n;
   // ==========================================================
   // mode outputs
   logic [15:0] mc;
   assign mc = regs[cfg_port_pkg::REG_MODE_CONTROL];
   assign measure_start = mc[cfg_port_pkg::MC_MEASURE];
   assign measure_rssi = rx_state;
   assign filter_bank_cal_start = mc[cfg_port_pkg::MC_FB_CAL];
   assign osc_bank_cal_start = mc[cfg_port_pkg::MC_OSC_CAL];
   assign tx_active = mc[cfg_port_pkg::MC_TRX_EN] && mc[cfg_port_pkg::MC_DIR];
   assign rx_active = mc[cfg_port_pkg::MC_TRX_EN] && !mc[cfg_port_pkg::MC_DIR];
   assign synth_enable = mc[cfg_port_pkg::MC_SYNTH];
   assign chip_on = mc[cfg_port_pkg::MC_CHIP_ON];
   assign packet_mode_select = mc[cfg_port_pkg::MC_PKT_MODE];
   assign packet_test_mode = mc[cfg_port_pkg::MC_PKT_TEST] && mc[cfg_port_pkg::MC_PKT_MODE];
endmodule

// ==== verilog/cfg_port_host.sv ====
/*
 * host end: an APB slave that takes one frame order and plays it on the link.
 * assumes the device samples the link on a fast clock; sck half period is 50 ns.
 */
`timescale 1ns/1ps
module cfg_port_host (
   input wire logic clock, // system clock
   input wire logic rst, // synchronous, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [31:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   cfg_link_if.host link // three-wire link
);
   // registers: 0x0 command {addr[7:0], data[15:0]} write starts;
   // 0x4 length in data bits (16/32); 0x8 status {busy}; 0xc read data
   localparam logic [3:0] OFF_CMD = 4'h0;
   localparam logic [3:0] OFF_LEN = 4'h4;
   localparam logic [3:0] OFF_STAT = 4'h8;
   localparam logic [3:0] OFF_RDATA = 4'hc;
   typedef enum {IDLE, LOW, HIGH, DONE} state_t;
   state_t state;
   logic [39:0] tx_shift;
   logic [31:0] rx_data;
   logic [5:0] len, bits_left;
   logic [3:0] div;
   logic rd;
   logic [1:0] sdi_sync;
   always_ff @(posedge clock) sdi_sync <= {sdi_sync[0], link.sdio_in};
   // apb: zero wait states
   logic acc, start;
   assign acc = psel && penable;
   assign pready = 1'b1;
   assign pslverr = acc && paddr[31:4] != 28'h0;
   assign start = acc && pwrite && paddr[3:0] == OFF_CMD && state == IDLE;
   always_comb begin
      case (paddr[3:0])
         OFF_LEN: prdata = {26'h0, len};
         OFF_STAT: prdata = {31'h0, state != IDLE};
         OFF_RDATA: prdata = rx_data;
         default: prdata = 32'h0;
      endcase
   end
   always_ff @(posedge clock) begin
      if (rst) len <= 6'h10;
      else if (acc && pwrite && paddr[3:0] == OFF_LEN) len <= pwdata[5:0];
   end
   // frame engine: sck idles low, data changes on falling edge
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= IDLE;
         div <= 4'h0;
         tx_shift <= 40'h0;
         rx_data <= 32'h0;
         bits_left <= 6'h0;
         rd <= 1'b0;
      end else begin
         case (state)
            IDLE: begin
               if (start) begin
                  tx_shift <= {pwdata[23:16], pwdata[15:0], 16'h0};
                  rd <= pwdata[23];
                  bits_left <= 6'(cfg_port_pkg::ADDR_BITS) + len;
                  div <= cfg_port_pkg::SCK_HALF_CYCLES;
                  state <= LOW;
               end
            end
            LOW: begin
               div <= div - 4'h1;
               if (div == 4'h1) begin
                  div <= cfg_port_pkg::SCK_HALF_CYCLES;
                  state <= HIGH;
               end
            end
            HIGH: begin
               div <= div - 4'h1;
               if (div == 4'h1) begin
                  div <= cfg_port_pkg::SCK_HALF_CYCLES;
                  tx_shift <= {tx_shift[38:0], 1'b0};
                  // sample returned data at the falling edge
                  if (bits_left <= len) rx_data <= {rx_data[30:0], sdi_sync[1]};
                  bits_left <= bits_left - 6'h1;
                  state <= (bits_left == 6'h1) ? DONE : LOW;
               end
            end
            DONE: state <= IDLE; // select high between frames
            default: state <= IDLE;
         endcase
      end
   end
   assign link.serial_select_n = !(state == LOW || state == HIGH);
   assign link.sck = state == HIGH;
   assign link.sdio_host_out = tx_shift[39];
   // release the line after the address byte on a read
   assign link.sdio_host_oe = (state == LOW || state == HIGH)
      && !(rd && bits_left <= len);
endmodule
